// ===== hw/crpsc_params.svh
// timing constants, capture widths and special-cycle codes for the reset and power state controller
`ifndef CRPSC_PARAMS_SVH
`define CRPSC_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define CRPSC_CLK_PERIOD_NS    10
`define CRPSC_OUT_RELEASE_CLKS 2
`define CRPSC_SYNC_STAGES      2

// ----------------------------------------------------------------------------
// acknowledge cycle codes and configuration capture
// ----------------------------------------------------------------------------
`define CRPSC_ACK_NONE      2'h0
`define CRPSC_ACK_STOPGRANT 2'h1
`define CRPSC_ACK_MGMT      2'h2
`define CRPSC_CFG_WIDTH     8
`define CRPSC_CFG_RESET     8'h00

`endif

// ===== hw/crpsc_pkg.sv
// types shared by the reset and power state controller
package crpsc_pkg;
    // one-hot power state codes
    typedef enum logic [4:0] {
        CRPSC_ST_RESET = 5'h01,
        CRPSC_ST_RUN   = 5'h02,
        CRPSC_ST_GRANT = 5'h04,
        CRPSC_ST_SLEEP = 5'h08,
        CRPSC_ST_MGMT  = 5'h10
    } crpsc_state_t;

    typedef logic [1:0] crpsc_ack_t;
endpackage : crpsc_pkg

// ===== hw/crpsc_sync.sv
// two-or-more stage level synchroniser into the bus clock domain
`timescale 1ns/1ps
`default_nettype none
module crpsc_sync #(
    parameter int STAGES = 2,
    parameter logic RESET_VAL = 1'b1
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // asynchronous level in, synchronised level out
    input  wire logic async_in,
    output var  logic sync_out
);
    logic [STAGES-1:0] chain_q;

    initial begin
        if (STAGES < 2) begin
            $error("crpsc_sync needs at least two stages");
        end
    end

    // only the next stage reads the first flop, to contain metastability
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= {STAGES{RESET_VAL}};
        end else begin
            chain_q <= {chain_q[STAGES-2:0], async_in};
        end
    end

    assign sync_out = chain_q[STAGES-1];
endmodule : crpsc_sync
`default_nettype wire

// ===== hw/crpsc_ctrl.sv
// reset, stop-grant, sleep and management-mode sequencing for the processor
//
// Overview of operation
// - cold init clears state and discards cache contents
// - bus outputs released within three clocks
// - capture configuration on cold init release
// - sleep in grant gates clocks, pll runs
// - sleep ignores snoops and interrupts
// - sleep release returns to grant, restarts clocks
// - clock-stop request enters grant, issues acknowledge
// - grant keeps snooping and servicing interrupts
// - clock-stop release restarts clocks, resumes execution
// - clock-stop is asynchronous, bus clock untouched
// - management interrupt saves state, acknowledges, runs handler
// - management interrupt at reset release floats outputs
`timescale 1ns/1ps
`default_nettype none
`include "crpsc_params.svh"
module crpsc_ctrl #(
    parameter int CFG_WIDTH   = `CRPSC_CFG_WIDTH,
    parameter int SYNC_STAGES = `CRPSC_SYNC_STAGES
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // platform control pins, asynchronous
    input  wire logic                    cold_init_n,
    input  wire logic                    supply_ok,
    input  wire logic                    clock_stop_request_n,
    input  wire logic                    sleep_request_n,
    input  wire logic                    sys_mgmt_irq_n,
    // bus pins sampled as power-on configuration
    input  wire logic [CFG_WIDTH-1:0]    cfg_pins,
    // core handshake: state saved on management entry
    input  wire logic                    mgmt_state_saved,
    // clock gating and core control
    output logic                         core_clk_en,
    output logic                         bus_clk_en,
    output logic                         irq_ctrl_clk_en,
    output logic                         snoop_en,
    output logic                         irq_accept_en,
    output logic                         cache_invalidate,
    output logic                         state_clear,
    output logic                         mgmt_save_req,
    output logic                         mgmt_exec_mode,
    output logic                         mgmt_handler_start,
    // bus output control and acknowledge cycles
    output logic                         bus_out_en,
    output logic                         outputs_float,
    output crpsc_pkg::crpsc_ack_t        ack_cycle,
    output logic [CFG_WIDTH-1:0]         cfg_latched,
    output crpsc_pkg::crpsc_state_t      power_state
);
    import crpsc_pkg::*;

    initial begin
        if (CFG_WIDTH < 1 || SYNC_STAGES < 2) begin
            $error("crpsc_ctrl: bad CFG_WIDTH or SYNC_STAGES");
        end
    end

    // ------------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------------
    logic init_s_n, pok_s, stop_s_n, slp_s_n, smi_s_n;
    logic [CFG_WIDTH-1:0] cfg_s;

    crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_init (.mclk(mclk), .rst_n(rst_n),
        .async_in(cold_init_n), .sync_out(init_s_n));
    crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_pok (.mclk(mclk), .rst_n(rst_n),
        .async_in(supply_ok), .sync_out(pok_s));
    crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_stop (.mclk(mclk), .rst_n(rst_n),
        .async_in(clock_stop_request_n), .sync_out(stop_s_n));
    crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_slp (.mclk(mclk), .rst_n(rst_n),
        .async_in(sleep_request_n), .sync_out(slp_s_n));
    crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b1)) u_sync_smi (.mclk(mclk), .rst_n(rst_n),
        .async_in(sys_mgmt_irq_n), .sync_out(smi_s_n));

    genvar gi;
    generate
        for (gi = 0; gi < CFG_WIDTH; gi++) begin : g_cfg_sync
            crpsc_sync #(.STAGES(SYNC_STAGES), .RESET_VAL(1'b0)) u_sync_cfg (.mclk(mclk), .rst_n(rst_n),
                .async_in(cfg_pins[gi]), .sync_out(cfg_s[gi]));
        end
    endgenerate

    // ------------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------------
    crpsc_state_t state_q, state_d;
    logic         init_prev_q;
    logic         float_q;
    logic [CFG_WIDTH-1:0] cfg_q;
    crpsc_ack_t   ack_q, ack_d;
    logic         saved_q;

    // the reset is treated as held while supply is not good
    wire in_reset    = ~init_s_n | ~pok_s;
    wire init_rise   = init_s_n & ~init_prev_q & pok_s;   // release edge of cold init
    wire stop_req    = ~stop_s_n;
    wire slp_req     = ~slp_s_n;
    wire smi_req     = ~smi_s_n;
    wire st_reset    = (state_q == CRPSC_ST_RESET);
    wire st_run      = (state_q == CRPSC_ST_RUN);
    wire st_grant    = (state_q == CRPSC_ST_GRANT);
    wire st_sleep    = (state_q == CRPSC_ST_SLEEP);
    wire st_mgmt     = (state_q == CRPSC_ST_MGMT);

    // ------------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------------
    // cold init overrides every state, sleep included
    always_comb begin
        state_d = state_q;
        ack_d   = `CRPSC_ACK_NONE;
        case (state_q)
            CRPSC_ST_RESET: begin
                if (init_rise && !smi_req) begin
                    state_d = CRPSC_ST_RUN;
                end
            end
            CRPSC_ST_RUN: begin // sleep request is not decoded here
                if (stop_req) begin
                    state_d = CRPSC_ST_GRANT;
                    ack_d   = `CRPSC_ACK_STOPGRANT;
                end else if (smi_req) begin
                    state_d = CRPSC_ST_MGMT;
                end
            end
            CRPSC_ST_GRANT: begin
                if (slp_req) begin
                    state_d = CRPSC_ST_SLEEP;
                end else if (!stop_req) begin
                    state_d = CRPSC_ST_RUN;
                end
            end
            CRPSC_ST_SLEEP: begin
                if (!slp_req) begin
                    state_d = CRPSC_ST_GRANT;
                end
            end
            CRPSC_ST_MGMT: begin
                if (stop_req) begin
                    state_d = CRPSC_ST_GRANT;
                    ack_d   = `CRPSC_ACK_STOPGRANT;
                end
            end
            default: begin
                state_d = CRPSC_ST_RESET;
            end
        endcase
        if (in_reset) begin
            state_d = CRPSC_ST_RESET;
            ack_d   = `CRPSC_ACK_NONE;
        end
    end

    // management entry acknowledge goes out once the core reports state saved
    wire mgmt_ack_fire = st_mgmt & mgmt_state_saved & ~saved_q & ~in_reset;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= CRPSC_ST_RESET;
            ack_q       <= `CRPSC_ACK_NONE;
            init_prev_q <= 1'b0;
            saved_q     <= 1'b0;
        end else begin
            state_q     <= state_d;
            ack_q       <= mgmt_ack_fire ? `CRPSC_ACK_MGMT : ack_d;
            init_prev_q <= init_s_n;
            saved_q     <= st_mgmt & (saved_q | mgmt_state_saved);
        end
    end

    // ------------------------------------------------------------------------
    // configuration capture and output float
    // ------------------------------------------------------------------------
    // capture on the release edge; float is held until the next cold init
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q   <= CFG_WIDTH'(`CRPSC_CFG_RESET);
            float_q <= 1'b0;
        end else begin
            if (init_rise) begin
                cfg_q <= cfg_s;
            end
            if (in_reset) begin
                float_q <= 1'b0;
            end else if (init_rise && smi_req) begin
                float_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // pll is never gated here; bus clock and unit clocks are
    assign core_clk_en        = st_run | st_mgmt;
    assign bus_clk_en         = ~st_sleep & ~st_reset;
    assign irq_ctrl_clk_en    = ~st_sleep & ~st_reset;
    assign snoop_en           = st_run | st_grant | st_mgmt;
    assign irq_accept_en      = st_run | st_grant;
    assign cache_invalidate   = st_reset;
    assign state_clear        = st_reset;
    assign mgmt_save_req      = st_mgmt & ~saved_q;
    assign mgmt_exec_mode     = st_mgmt;
    assign mgmt_handler_start = st_mgmt & saved_q & (ack_q == `CRPSC_ACK_NONE);
    // two sync flops and the state register give the release within three clocks of the pin
    assign bus_out_en         = ~st_reset & ~float_q;
    assign outputs_float      = float_q;
    assign ack_cycle          = ack_q;
    assign cfg_latched        = cfg_q;
    assign power_state        = state_q;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_reset_release: assert property (in_reset |=> !bus_out_en)
        else $error("bus outputs not released during cold init");
    chk_reset_clear: assert property (in_reset |=> cache_invalidate && state_clear)
        else $error("cold init did not clear state");
    chk_cfg_capture: assert property (init_rise |=> cfg_latched == $past(cfg_s))
        else $error("configuration not captured on release");
    chk_sleep_entry: assert property (st_grant && slp_req && !in_reset |=>
        st_sleep && !core_clk_en && !bus_clk_en)
        else $error("sleep entry failed");
    chk_sleep_quiet: assert property (st_sleep |-> !snoop_en && !irq_accept_en)
        else $error("sleep still snooping");
    chk_sleep_exit: assert property (st_sleep && !slp_req && !in_reset |=> st_grant && bus_clk_en)
        else $error("sleep exit failed");
    chk_grant_entry: assert property (st_run && stop_req && !in_reset |=>
        st_grant && ack_cycle == `CRPSC_ACK_STOPGRANT)
        else $error("stop-grant entry or acknowledge missing");
    chk_grant_snoop: assert property (st_grant |-> snoop_en && irq_accept_en && !core_clk_en)
        else $error("grant state not snooping");
    chk_grant_exit: assert property (st_grant && !stop_req && !slp_req && !in_reset |=>
        st_run && core_clk_en)
        else $error("grant exit failed");
    chk_mgmt_ack: assert property (mgmt_ack_fire |=>
        (ack_cycle == `CRPSC_ACK_MGMT) ##1 (mgmt_handler_start || in_reset))
        else $error("management acknowledge sequence wrong");
    chk_float: assert property (init_rise && smi_req |=> !bus_out_en [*2])
        else $error("outputs not floated");
    chk_no_sleep: assert property (!st_grant && !st_sleep |=> !st_sleep)
        else $error("sleep entered outside grant");

    cov_grant: cover property (st_run ##1 st_grant);
    cov_sleep: cover property (st_grant ##1 st_sleep ##[1:20] st_grant);
    cov_mgmt: cover property (mgmt_ack_fire ##2 mgmt_handler_start);
    cov_float: cover property (init_rise && smi_req);
endmodule : crpsc_ctrl
`default_nettype wire

// ===== tb/crpsc_platform.sv
// platform model: supply-ok, cold init pulse and the core's save handshake
`timescale 1ns/1ps
`default_nettype none
module crpsc_platform #(
    parameter int INIT_CLKS = 20,
    parameter int SAVE_CLKS = 3
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // bench command and core handshake
    input  wire logic init_req,
    input  wire logic mgmt_save_req,
    // platform pins
    output var  logic supply_ok,
    output logic      cold_init_n,
    output logic      mgmt_state_saved
);
    // ------------------------------------------------------------------
    // pulse and handshake counters
    // ------------------------------------------------------------------
    logic [7:0] init_cnt_q;
    logic [3:0] save_cnt_q;

    // pulse is scaled from ms to clocks so the run stays short
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_ok  <= 1'b0;
            init_cnt_q <= 8'(INIT_CLKS);
            save_cnt_q <= 4'h0;
        end else begin
            supply_ok <= 1'b1;
            if (init_req) begin
                init_cnt_q <= 8'(INIT_CLKS);
            end else if (supply_ok && init_cnt_q != 8'h00) begin
                init_cnt_q <= init_cnt_q - 8'h01;
            end
            // a slow core: saving takes a few clocks, never zero
            if (!mgmt_save_req) begin
                save_cnt_q <= 4'h0;
            end else if (save_cnt_q != 4'(SAVE_CLKS)) begin
                save_cnt_q <= save_cnt_q + 4'h1;
            end
        end
    end
    assign cold_init_n      = (init_cnt_q == 8'h00);
    assign mgmt_state_saved = (save_cnt_q == 4'(SAVE_CLKS));
endmodule : crpsc_platform
`default_nettype wire

// ===== tb/cpu_reset_and_power_state_control_tb.sv
// self-checking bench for the reset and power state controller
`timescale 1ns/1ps
`default_nettype none
module cpu_reset_and_power_state_control_tb;
    import crpsc_pkg::*;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic mclk, rst_n, init_req, stop_n, sleep_n, mgmt_n, saved, sup_ok, cold_n;
    logic core_en, bus_en, irq_en, snoop, irq_acc, cache_inv, clr, save_req;
    logic mode, hstart, bus_oe, flt;
    logic [7:0] cfg, cfg_q;
    crpsc_ack_t ack;
    crpsc_state_t st;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;

    crpsc_ctrl DUT (.mclk(mclk), .rst_n(rst_n), .cold_init_n(cold_n), .supply_ok(sup_ok),
        .clock_stop_request_n(stop_n), .sleep_request_n(sleep_n), .sys_mgmt_irq_n(mgmt_n),
        .cfg_pins(cfg), .mgmt_state_saved(saved), .core_clk_en(core_en), .bus_clk_en(bus_en),
        .irq_ctrl_clk_en(irq_en), .snoop_en(snoop), .irq_accept_en(irq_acc),
        .cache_invalidate(cache_inv), .state_clear(clr), .mgmt_save_req(save_req),
        .mgmt_exec_mode(mode), .mgmt_handler_start(hstart), .bus_out_en(bus_oe),
        .outputs_float(flt), .ack_cycle(ack), .cfg_latched(cfg_q), .power_state(st));
    crpsc_platform PLAT (.mclk(mclk), .rst_n(rst_n), .init_req(init_req), .mgmt_save_req(save_req),
        .supply_ok(sup_ok), .cold_init_n(cold_n), .mgmt_state_saved(saved));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // sample just after the edge so its updates have landed
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task wait_st(input crpsc_state_t s);
        int n;
        n = 0;
        while (st !== s && n < 40) begin
            tick(1);
            n++;
        end
    endtask : wait_st
    task wait_init_done;
        int n;
        n = 0;
        while (cold_n !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
    endtask : wait_init_done
    task give_verdict;
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task power_on;
        check("state in init", st, CRPSC_ST_RESET);
        check("invalidate", cache_inv, 1'b1);
        check("clear", clr, 1'b1);
        check("bus out in init", bus_oe, 1'b0);
        wait_st(CRPSC_ST_RUN);
        check("cfg captured", cfg_q, 8'h5a);
        @(posedge mclk) cfg <= 8'hc3;
        tick(6);
        check("cfg held", cfg_q, 8'h5a);
        check("bus out run", bus_oe, 1'b1);
        check("invalidate done", cache_inv, 1'b0);
    endtask : power_on
    task stop_grant;
        @(posedge mclk) stop_n <= 1'b0;
        tick(2);
        check("not yet synced", st, CRPSC_ST_RUN);
        tick(1);
        check("grant", st, CRPSC_ST_GRANT);
        check("grant ack", ack, 2'h1);
        check("core gated", core_en, 1'b0);
        check("bus clk on", bus_en, 1'b1);
        check("irq ctrl on", irq_en, 1'b1);
        check("snoop in grant", snoop, 1'b1);
        check("irq in grant", irq_acc, 1'b1);
        tick(1);
        check("ack one cycle", ack, 2'h0);
    endtask : stop_grant
    task sleep_cycle;
        @(posedge mclk) sleep_n <= 1'b0;
        wait_st(CRPSC_ST_SLEEP);
        check("sleep", st, CRPSC_ST_SLEEP);
        check("sleep core", core_en, 1'b0);
        check("sleep bus", bus_en, 1'b0);
        check("sleep snoop", snoop, 1'b0);
        check("sleep irq", irq_acc, 1'b0);
        @(posedge mclk) mgmt_n <= 1'b0;
        tick(6);
        check("mgmt ignored", st, CRPSC_ST_SLEEP);
        @(posedge mclk) mgmt_n <= 1'b1;
        tick(4);
        @(posedge mclk) sleep_n <= 1'b1;
        wait_st(CRPSC_ST_GRANT);
        check("wake grant", st, CRPSC_ST_GRANT);
        check("wake bus", bus_en, 1'b1);
        @(posedge mclk) stop_n <= 1'b1;
        wait_st(CRPSC_ST_RUN);
        check("resume", st, CRPSC_ST_RUN);
        check("resume core", core_en, 1'b1);
    endtask : sleep_cycle
    task sleep_in_run;
        @(posedge mclk) sleep_n <= 1'b0;
        tick(6);
        check("sleep refused", st, CRPSC_ST_RUN);
        @(posedge mclk) sleep_n <= 1'b1;
        tick(4);
    endtask : sleep_in_run
    task mgmt_entry;
        int n;
        @(posedge mclk) mgmt_n <= 1'b0;
        wait_st(CRPSC_ST_MGMT);
        check("save req", save_req, 1'b1);
        check("mgmt mode", mode, 1'b1);
        check("no early handler", hstart, 1'b0);
        n = 0;
        while (ack !== 2'h2 && n < 20) begin
            tick(1);
            n++;
        end
        check("mgmt ack", ack, 2'h2);
        check("save done", save_req, 1'b0);
        check("handler after ack", hstart, 1'b0);
        tick(1);
        check("handler", hstart, 1'b1);
        @(posedge mclk) mgmt_n <= 1'b1;
        stop_n <= 1'b0;
        wait_st(CRPSC_ST_GRANT);
        check("mgmt left", mode, 1'b0);
        @(posedge mclk) stop_n <= 1'b1;
        wait_st(CRPSC_ST_RUN);
    endtask : mgmt_entry
    task cold_init_float;
        @(posedge mclk) init_req <= 1'b1;
        @(posedge mclk) init_req <= 1'b0;
        tick(3);
        check("bus released", bus_oe, 1'b0);
        check("reinit clear", cache_inv, 1'b1);
        @(posedge mclk) mgmt_n <= 1'b0;
        wait_init_done();
        tick(4);
        check("float", flt, 1'b1);
        check("float bus", bus_oe, 1'b0);
        check("cfg recaptured", cfg_q, 8'hc3);
        @(posedge mclk) mgmt_n <= 1'b1;
        @(posedge mclk) init_req <= 1'b1;
        @(posedge mclk) init_req <= 1'b0;
        wait_st(CRPSC_ST_RUN);
        check("float cleared", flt, 1'b0);
        check("bus back", bus_oe, 1'b1);
    endtask : cold_init_float

    // ------------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // the whole run needs well under a thousand clocks
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        rst_n = 1'b0;
        init_req = 1'b0;
        stop_n = 1'b1;
        sleep_n = 1'b1;
        mgmt_n = 1'b1;
        cfg = 8'h5a;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        tick(1);
        power_on();
        stop_grant();
        sleep_cycle();
        sleep_in_run();
        mgmt_entry();
        cold_init_float();
        give_verdict();
    end
endmodule : cpu_reset_and_power_state_control_tb
`default_nettype wire
